/* File: pmv_port_ctrl_top.sv */
// Top of the per-port mirror, VLAN membership and flow control register bank with its packet decision.
`timescale 1ns/1ps
`default_nettype none
module pmv_port_ctrl_top
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Switch management register interface.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  // Strap pins, sampled once after reset release.
  input wire logic port1_member3_strap,
  input wire logic port1_member2_strap,
  input wire logic port2_member3_strap,
  input wire logic port2_member1_strap,
  input wire logic port3_member2_strap,
  input wire logic port3_member1_strap,
  input wire logic port1_force_pause_strap,
  input wire logic port2_force_pause_strap,
  // Packet descriptor from the lookup engine.
  input wire logic pkt_valid,
  input wire logic [1:0] pkt_src_port,
  input wire logic [2:0] pkt_dst_lookup,
  input wire logic [11:0] pkt_vid,
  input wire logic [18:0] pkt_vlan_entry,
  input wire logic [35:0] port_default_vid,
  // Packet decision, one cycle after the descriptor.
  output logic fwd_valid,
  output logic [2:0] fwd_mask,
  output logic fwd_drop,
  output logic fwd_monitored,
  output logic fwd_push_tag,
  output logic [11:0] fwd_tag_vid,
  // Per-port settings to the switch core, bit i for port i+1.
  output logic [2:0] port_sniffer_dest,
  output logic [2:0] port_rx_sniff,
  output logic [2:0] port_tx_sniff,
  output logic [2:0] port_double_tag,
  output logic [8:0] port_member_mask,
  output logic [2:0] port_ingress_filter,
  output logic [2:0] port_discard_non_port_default_vid,
  output logic [2:0] port_force_fc
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  // All state of the top in one record.
  typedef struct packed
  {
    logic strap_done;
    logic [7:0] rdata;
    logic rvalid;
    logic fvalid;
    logic [2:0] fmask;
    logic fdrop;
    logic fmon;
    logic fpush;
    logic [11:0] fvid;
    logic [2:0] ffc;
  } pmv_top_state_t;

  // Current and next state.
  pmv_top_state_t st_ff;
  pmv_top_state_t nxt_st;

  // Register contents of each port.
  logic [7:0] ctrl1 [pmv_pkg::NUM_PORTS];
  logic [7:0] ctrl2 [pmv_pkg::NUM_PORTS];
  // Strap vectors per port.
  logic [2:0] strap_member [pmv_pkg::NUM_PORTS];
  logic strap_fc [pmv_pkg::NUM_PORTS];
  // Strap load pulse in the first cycle after reset release.
  logic strap_load;
  // Decision from the combinational calculator.
  logic [2:0] calc_mask;
  logic calc_drop;
  logic calc_mon;
  logic calc_push;
  logic [11:0] calc_vid;
  logic [2:0] calc_member;

  ////////////////////////////////////////////////////////////////////////////////
  // Straps. Own member bit is hard 1; the other two follow the pins.

  // Port 3 has no force strap, its force bit loads zero.
  assign strap_member[0] = {port1_member3_strap, port1_member2_strap, 1'b1}; // [RULE12]
  assign strap_member[1] = {port2_member3_strap, 1'b1, port2_member1_strap}; // [RULE12]
  assign strap_member[2] = {1'b1, port3_member2_strap, port3_member1_strap}; // [RULE12]
  assign strap_fc[0] = port1_force_pause_strap;
  assign strap_fc[1] = port2_force_pause_strap;
  assign strap_fc[2] = 1'b0;
  // The pins are caught by a clocked load after release, never by the reset itself.
  assign strap_load = !st_ff.strap_done;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port register pairs.
  for (genvar gi = 0; gi < pmv_pkg::NUM_PORTS; gi++)
  begin : g_port
    // Write strobes decoded from the register address.
    logic wr1;
    logic wr2;
    assign wr1 = reg_wr && pmv_pkg::pmv_hit(reg_addr, 2'(gi), pmv_pkg::SEL_CTRL1); // [RULE1]
    assign wr2 = reg_wr && pmv_pkg::pmv_hit(reg_addr, 2'(gi), pmv_pkg::SEL_CTRL2); // [RULE1]

    // Storage of this port.
    pmv_port_regs u_regs
    (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .strap_load(strap_load),
      .strap_member(strap_member[gi]),
      .strap_force_fc(strap_fc[gi]),
      .wr_ctrl1(wr1),
      .wr_ctrl2(wr2),
      .wdata(reg_wdata),
      .ctrl1(ctrl1[gi]),
      .ctrl2(ctrl2[gi])
    );

    // Fields to the switch core, taken straight from the register flops.
    assign port_sniffer_dest[gi] = ctrl1[gi][pmv_pkg::C1_SNIFFER_BIT]; // [RULE2]
    assign port_rx_sniff[gi] = ctrl1[gi][pmv_pkg::C1_RX_SNIFF_BIT]; // [RULE3]
    assign port_tx_sniff[gi] = ctrl1[gi][pmv_pkg::C1_TX_SNIFF_BIT]; // [RULE4]
    assign port_double_tag[gi] = ctrl1[gi][pmv_pkg::C1_DOUBLE_TAG_BIT]; // [RULE5]
    assign port_member_mask[3*gi +: 3] = ctrl1[gi][pmv_pkg::C1_MEMBER_LSB +: 3]; // [RULE7]
    assign port_ingress_filter[gi] = ctrl2[gi][pmv_pkg::C2_INGRESS_FILTER_BIT]; // [RULE9]
    assign port_discard_non_port_default_vid[gi] = ctrl2[gi][pmv_pkg::C2_DISCARD_NON_PORT_DEFAULT_VID_BIT]; // [RULE10]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Packet decision.
  pmv_fwd_calc u_calc
  (
    .src_port(pkt_src_port),
    .dst_lookup(pkt_dst_lookup),
    .pkt_vid(pkt_vid),
    .vlan_entry(pkt_vlan_entry),
    .port_default_vid(port_default_vid),
    .sniffer_dest(port_sniffer_dest),
    .rx_sniff(port_rx_sniff),
    .tx_sniff(port_tx_sniff),
    .double_tag(port_double_tag),
    .member_mask(port_member_mask),
    .ingress_filter(port_ingress_filter),
    .discard_non_port_default_vid(port_discard_non_port_default_vid),
    .fwd_mask(calc_mask),
    .drop(calc_drop),
    .monitored(calc_mon),
    .push_tag(calc_push),
    .tag_vid(calc_vid),
    .src_member(calc_member)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: read data, registered decision, flow control outputs.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.strap_done = 1'b1;
    nxt_st.rvalid = reg_rd;
    // Read multiplexer; unmapped addresses answer zero.
    if (reg_rd)
    begin
      nxt_st.rdata = pmv_pkg::RD_UNMAPPED;
      for (int i = 0; i < pmv_pkg::NUM_PORTS; i++)
      begin
        if (pmv_pkg::pmv_hit(reg_addr, 2'(i), pmv_pkg::SEL_CTRL1))
        begin
          nxt_st.rdata = ctrl1[i]; // [RULE1]
        end
        else if (pmv_pkg::pmv_hit(reg_addr, 2'(i), pmv_pkg::SEL_CTRL2))
        begin
          nxt_st.rdata = ctrl2[i]; // [RULE1]
        end
      end
    end
    // Decision is held between packets; fwd_valid marks a fresh one.
    nxt_st.fvalid = pkt_valid;
    if (pkt_valid)
    begin
      nxt_st.fmask = calc_mask;
      nxt_st.fdrop = calc_drop;
      nxt_st.fmon = calc_mon;
      nxt_st.fpush = calc_push;
      nxt_st.fvid = calc_vid;
    end
    // Port 3 force bit is storage only; its flow control output is tied to zero.
    nxt_st.ffc = {1'b0, ctrl2[1][pmv_pkg::C2_FORCE_FC_BIT], ctrl2[0][pmv_pkg::C2_FORCE_FC_BIT]}; // [RULE11]
  end

  // State register.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs from the flops.
  assign reg_rdata = st_ff.rdata;
  assign reg_rdata_valid = st_ff.rvalid;
  assign fwd_valid = st_ff.fvalid;
  assign fwd_mask = st_ff.fmask;
  assign fwd_drop = st_ff.fdrop;
  assign fwd_monitored = st_ff.fmon;
  assign fwd_push_tag = st_ff.fpush;
  assign fwd_tag_vid = st_ff.fvid;
  assign port_force_fc = st_ff.ffc;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  // An unmapped read answers zero next cycle.
  property p_rd_unmapped;
    @(posedge clk_sys) disable iff (!nrst)
    reg_rd && (reg_addr == 8'h00) |=> reg_rdata_valid && (reg_rdata == pmv_pkg::RD_UNMAPPED);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero"); // [RULE1]

  // A write to port 2 control 1, one idle cycle, then a read returns the written byte.
  property p_rd_back;
    @(posedge clk_sys) disable iff (!nrst)
    reg_wr && !reg_rd && !strap_load && (reg_addr == pmv_pkg::PORT2_MIRROR_VLAN_CTRL_OFS)
      ##1 !reg_wr ##1 reg_rd && !reg_wr && (reg_addr == pmv_pkg::PORT2_MIRROR_VLAN_CTRL_OFS)
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_rd_back: assert property (p_rd_back) else $error("readback mismatch"); // [RULE1]

  // Port 3 control 2 bit 7 always reads zero.
  property p_c2_rsvd;
    @(posedge clk_sys) disable iff (!nrst)
    reg_rd && (reg_addr == pmv_pkg::PORT3_FILTER_FLOW_CTRL_OFS) |=> !reg_rdata[7];
  endproperty
  a_c2_rsvd: assert property (p_c2_rsvd) else $error("reserved bit set"); // [RULE1]

  // Member mask write lands in bit order 3, 2, 1.
  property p_member_wr;
    @(posedge clk_sys) disable iff (!nrst)
    reg_wr && !strap_load && (reg_addr == pmv_pkg::PORT1_MIRROR_VLAN_CTRL_OFS)
      |=> port_member_mask[2:0] == $past(reg_wdata[2:0]);
  endproperty
  a_member_wr: assert property (p_member_wr) else $error("member mask not stored"); // [RULE7]

  // Receive sniff sends a copy to every other sniffer port.
  property p_rx_mirror;
    @(posedge clk_sys) disable iff (!nrst)
    pkt_valid && !calc_drop && (pkt_src_port == 2'h0) && port_rx_sniff[0]
      |=> fwd_monitored && ((fwd_mask & $past(port_sniffer_dest) & 3'h6) == ($past(port_sniffer_dest) & 3'h6));
  endproperty
  a_rx_mirror: assert property (p_rx_mirror) else $error("rx mirror copy missing"); // [RULE2] [RULE3]

  // Transmit sniff on an egress port marks the packet monitored.
  property p_tx_mirror;
    @(posedge clk_sys) disable iff (!nrst)
    pkt_valid && !calc_drop && ((calc_member & pkt_dst_lookup & port_tx_sniff & ~(3'h1 << pkt_src_port)) != 3'h0)
      |=> fwd_monitored;
  endproperty
  a_tx_mirror: assert property (p_tx_mirror) else $error("tx mirror not marked"); // [RULE4]

  // Unmonitored traffic stays inside the source membership.
  property p_membership;
    @(posedge clk_sys) disable iff (!nrst)
    pkt_valid && !calc_mon |=> (fwd_mask & ~$past(calc_member)) == 3'h0;
  endproperty
  a_membership: assert property (p_membership) else $error("forward outside membership"); // [RULE8]

  // Ingress VLAN filter drops a non-member packet with an empty mask.
  property p_vlan_drop;
    @(posedge clk_sys) disable iff (!nrst)
    pkt_valid && (pkt_src_port == 2'h1) && port_ingress_filter[1] && !pkt_vlan_entry[pmv_pkg::VT_MEMBER_LSB + 1]
      |=> fwd_valid && fwd_drop && (fwd_mask == 3'h0);
  endproperty
  a_vlan_drop: assert property (p_vlan_drop) else $error("vlan filter missed"); // [RULE9]

  // Non-default VID is dropped when discard is on.
  property p_port_default_vid_drop;
    @(posedge clk_sys) disable iff (!nrst)
    pkt_valid && (pkt_src_port == 2'h2) && port_discard_non_port_default_vid[2] && (pkt_vid != port_default_vid[35:24])
      |=> fwd_drop && !fwd_push_tag;
  endproperty
  a_port_default_vid_drop: assert property (p_port_default_vid_drop) else $error("non-default vid kept"); // [RULE10]

  // Double tag follows the ingress port setting with its default VID.
  property p_dbl_tag;
    @(posedge clk_sys) disable iff (!nrst)
    pkt_valid && !calc_drop && (pkt_src_port == 2'h0)
      |=> (fwd_push_tag == $past(port_double_tag[0])) && (fwd_tag_vid == $past(port_default_vid[11:0]));
  endproperty
  a_dbl_tag: assert property (p_dbl_tag) else $error("double tag wrong"); // [RULE5] [RULE12]

  // Forced flow control follows the bit a cycle later; port 3 never forces.
  property p_force_fc;
    @(posedge clk_sys) disable iff (!nrst)
    ##1 (port_force_fc[1] == $past(ctrl2[1][pmv_pkg::C2_FORCE_FC_BIT])) && !port_force_fc[2];
  endproperty
  a_force_fc: assert property (p_force_fc) else $error("force flow control wrong"); // [RULE11]

  // After the strap load each port is a member of itself.
  property p_strap_self;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(st_ff.strap_done) |-> port_member_mask[0] && port_member_mask[4] && port_member_mask[8]
      && (port_member_mask[2:1] == {port1_member3_strap, port1_member2_strap});
  endproperty
  a_strap_self: assert property (p_strap_self) else $error("strap defaults wrong"); // [RULE12]

  // Main scenarios.
  c_mirror: cover property (@(posedge clk_sys) disable iff (!nrst) fwd_valid && fwd_monitored);
  c_drop: cover property (@(posedge clk_sys) disable iff (!nrst) fwd_valid && fwd_drop);
  c_wr_rd: cover property (@(posedge clk_sys) disable iff (!nrst) reg_wr ##1 reg_rd ##1 reg_rdata_valid);

endmodule
`default_nettype wire

/* File: pmv_pkg.sv */
// Constants, field layouts and address decode shared by the port mirror / VLAN / flow control register bank.
// Operation
// RULE1: Two 8-bit control registers per port, three ports.
// RULE2: Control-1 bit 7 makes the port the sniffer.
// RULE3: Control-1 bit 6 mirrors received packets to sniffer.
// RULE4: Control-1 bit 5 mirrors transmitted packets to sniffer.
// RULE5: Control-1 bit 4 double-tags every packet.
// RULE6: Software keeps reserved bits at zero.
// RULE7: Control-1 bits 2-0 map ports 3, 2, 1.
// RULE8: Forward only to member ports of source. Mirror copies go to sniffer ports whether members or not.
// RULE9: Control-2 bit 6 drops packets failing VLAN membership.
// RULE10: Control-2 bit 5 drops packets with non-default VID.
// RULE11: Control-2 bit 4 forces flow control, strapped default. Port 3's bit is unstrapped and only stored, port_force_fc[2] is 0.
// RULE12: Own member bit resets 1; outer tag prepended.
`default_nettype none
package pmv_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes.

  // Number of switch ports served by the bank.
  localparam int NUM_PORTS = 3;
  // Width of a register and of a VLAN identifier.
  localparam int REG_W = 8;
  localparam int VID_W = 12;
  // Width of a VLAN table entry as presented by the lookup.
  localparam int VT_W = 19;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map.

  // Byte addresses of the six registers.
  localparam logic [7:0] PORT1_MIRROR_VLAN_CTRL_OFS = 8'h11;
  localparam logic [7:0] PORT1_FILTER_FLOW_CTRL_OFS = 8'h12;
  localparam logic [7:0] PORT2_MIRROR_VLAN_CTRL_OFS = 8'h21;
  localparam logic [7:0] PORT2_FILTER_FLOW_CTRL_OFS = 8'h22;
  localparam logic [7:0] PORT3_MIRROR_VLAN_CTRL_OFS = 8'h31;
  localparam logic [7:0] PORT3_FILTER_FLOW_CTRL_OFS = 8'h32;
  // The upper nibble carries the port number, the lower nibble the register.
  localparam logic [3:0] PORT_NIBBLE_BASE = 4'h1;
  localparam logic [3:0] SEL_CTRL1 = 4'h1;
  localparam logic [3:0] SEL_CTRL2 = 4'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.

  // Control 1 fields.
  localparam int C1_SNIFFER_BIT = 7;
  localparam int C1_RX_SNIFF_BIT = 6;
  localparam int C1_TX_SNIFF_BIT = 5;
  localparam int C1_DOUBLE_TAG_BIT = 4;
  localparam int C1_MEMBER_LSB = 0;
  // Control 2 fields.
  localparam int C2_INGRESS_FILTER_BIT = 6;
  localparam int C2_DISCARD_NON_PORT_DEFAULT_VID_BIT = 5;
  localparam int C2_FORCE_FC_BIT = 4;
  // Membership field of a VLAN table entry.
  localparam int VT_MEMBER_LSB = 16;

  // Reset values and writable masks.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] C1_WR_MASK = 8'hFF;
  // Control 2 bit 7 has no storage and reads zero.
  localparam logic [7:0] C2_WR_MASK = 8'h7F;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode, used by the write strobes and the read multiplexer.

  // True when addr selects register sel of port index port (0 based).
  function automatic logic pmv_hit(input logic [7:0] addr, input logic [1:0] port, input logic [3:0] sel);
    logic [3:0] nib;
    nib = {2'h0, port} + PORT_NIBBLE_BASE;
    return addr == {nib, sel};
  endfunction

endpackage
`default_nettype wire

/* File: pmv_port_regs.sv */
// Storage of the two control registers of one switch port, with strap defaults.
`timescale 1ns/1ps
`default_nettype none
module pmv_port_regs
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Load of strap defaults, one pulse after reset release.
  input wire logic strap_load,
  input wire logic [2:0] strap_member,
  input wire logic strap_force_fc,
  // Write strobes and data.
  input wire logic wr_ctrl1,
  input wire logic wr_ctrl2,
  input wire logic [7:0] wdata,
  // Register contents.
  output logic [7:0] ctrl1,
  output logic [7:0] ctrl2
);

  // All state of this port.
  typedef struct packed
  {
    logic [7:0] c1;
    logic [7:0] c2;
  } pmv_port_state_t;

  // Current and next state.
  pmv_port_state_t st_ff;
  pmv_port_state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state. The strap load wins over a write in the same cycle, which can
  // only happen if software ignores the one-cycle settling time after reset.
  always_comb
  begin
    nxt_st = st_ff;
    if (strap_load)
    begin
      // Own member bit comes in already set from the strap vector. [RULE12]
      nxt_st.c1 = pmv_pkg::REG_RESET;
      nxt_st.c1[pmv_pkg::C1_MEMBER_LSB +: 3] = strap_member; // [RULE7]
      nxt_st.c2 = pmv_pkg::REG_RESET;
      nxt_st.c2[pmv_pkg::C2_FORCE_FC_BIT] = strap_force_fc; // [RULE11]
    end
    else
    begin
      // Plain stores; the reserved bit 3 of control 1 is kept as written.
      if (wr_ctrl1)
      begin
        nxt_st.c1 = wdata & pmv_pkg::C1_WR_MASK; // [RULE1]
      end
      if (wr_ctrl2)
      begin
        nxt_st.c2 = wdata & pmv_pkg::C2_WR_MASK; // [RULE1]
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= {pmv_pkg::REG_RESET, pmv_pkg::REG_RESET};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the flops.
  assign ctrl1 = st_ff.c1;
  assign ctrl2 = st_ff.c2;

endmodule
`default_nettype wire

/* File: pmv_fwd_calc.sv */
// Combinational forwarding, mirroring, filtering and tagging decision for one packet.
`timescale 1ns/1ps
`default_nettype none
module pmv_fwd_calc
(
  // Packet descriptor.
  input wire logic [1:0] src_port,
  input wire logic [2:0] dst_lookup,
  input wire logic [11:0] pkt_vid,
  input wire logic [18:0] vlan_entry,
  input wire logic [35:0] port_default_vid,
  // Per-port settings, bit i for port index i.
  input wire logic [2:0] sniffer_dest,
  input wire logic [2:0] rx_sniff,
  input wire logic [2:0] tx_sniff,
  input wire logic [2:0] double_tag,
  input wire logic [8:0] member_mask,
  input wire logic [2:0] ingress_filter,
  input wire logic [2:0] discard_non_port_default_vid,
  // Decision.
  output logic [2:0] fwd_mask,
  output logic drop,
  output logic monitored,
  output logic push_tag,
  output logic [11:0] tag_vid,
  output logic [2:0] src_member
);

  // Working values.
  logic [2:0] src_bit;
  logic [2:0] base;
  logic [2:0] mirror;
  logic drop_vlan;
  logic drop_port_default_vid;
  int idx;

  ////////////////////////////////////////////////////////////////////////////////
  // Decision. A source index outside the three ports is dropped outright.
  always_comb
  begin
    idx = int'(src_port);
    src_bit = 3'h0;
    src_member = 3'h0;
    tag_vid = 12'h000;
    base = 3'h0;
    mirror = 3'h0;
    drop_vlan = 1'b0;
    drop_port_default_vid = 1'b0;
    drop = 1'b1;
    monitored = 1'b0;
    push_tag = 1'b0;
    fwd_mask = 3'h0;
    if (idx < pmv_pkg::NUM_PORTS)
    begin
      src_bit[idx] = 1'b1;
      src_member = member_mask[3*idx +: 3];
      tag_vid = port_default_vid[pmv_pkg::VID_W*idx +: pmv_pkg::VID_W];
      // Normal traffic never leaves through a non-member or its own port. [RULE8]
      base = dst_lookup & src_member & ~src_bit;
      // Ingress filter checks the VLAN entry's port membership. [RULE9]
      drop_vlan = ingress_filter[idx] && !vlan_entry[pmv_pkg::VT_MEMBER_LSB + idx];
      // Non-default VID discard. [RULE10]
      drop_port_default_vid = discard_non_port_default_vid[idx] && (pkt_vid != tag_vid);
      drop = drop_vlan || drop_port_default_vid;
      // Receive sniff on the source or transmit sniff on any egress. [RULE3] [RULE4]
      monitored = !drop && (rx_sniff[idx] || ((base & tx_sniff) != 3'h0));
      // Copies go to every sniffer port except the one it came from. [RULE2]
      mirror = monitored ? (sniffer_dest & ~src_bit) : 3'h0;
      fwd_mask = drop ? 3'h0 : (base | mirror);
      // Outer tag is pushed ahead of any tag already carried. [RULE5] [RULE12]
      push_tag = !drop && double_tag[idx];
    end
  end

endmodule
`default_nettype wire

/* File: pmv_testbench.sv */
// Self-checking testbench of the port mirror, VLAN membership and flow control register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // Design connections.
  logic clk_sys, nrst, reg_wr, reg_rd, pkt_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, strap;
  logic reg_rdata_valid, fwd_valid, fwd_drop, fwd_monitored, fwd_push_tag;
  logic [1:0] pkt_src_port;
  logic [2:0] pkt_dst_lookup, fwd_mask, port_sniffer_dest, port_rx_sniff, port_tx_sniff;
  logic [2:0] port_double_tag, port_ingress_filter, port_discard_non_port_default_vid, port_force_fc;
  logic [11:0] pkt_vid, fwd_tag_vid;
  logic [18:0] pkt_vlan_entry;
  logic [35:0] port_default_vid;
  logic [8:0] port_member_mask;
  // Model of the six registers, index 0 for port 1.
  logic [7:0] c1 [3];
  logic [7:0] c2 [3];
  int seed = 54;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  pmv_port_ctrl_top uut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .port1_member3_strap(strap[0]), .port1_member2_strap(strap[1]), .port2_member3_strap(strap[2]),
    .port2_member1_strap(strap[3]), .port3_member2_strap(strap[4]), .port3_member1_strap(strap[5]),
    .port1_force_pause_strap(strap[6]), .port2_force_pause_strap(strap[7]), .pkt_valid(pkt_valid),
    .pkt_src_port(pkt_src_port), .pkt_dst_lookup(pkt_dst_lookup), .pkt_vid(pkt_vid),
    .pkt_vlan_entry(pkt_vlan_entry), .port_default_vid(port_default_vid), .fwd_valid(fwd_valid),
    .fwd_mask(fwd_mask), .fwd_drop(fwd_drop), .fwd_monitored(fwd_monitored), .fwd_push_tag(fwd_push_tag),
    .fwd_tag_vid(fwd_tag_vid), .port_sniffer_dest(port_sniffer_dest), .port_rx_sniff(port_rx_sniff),
    .port_tx_sniff(port_tx_sniff), .port_double_tag(port_double_tag), .port_member_mask(port_member_mask),
    .port_ingress_filter(port_ingress_filter), .port_discard_non_port_default_vid(port_discard_non_port_default_vid),
    .port_force_fc(port_force_fc));
  ////////////////////////////////////////////////////////////////////////////////
  // The 40 ns clock, and a cycle ceiling that cuts a hang short.
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      $display("BAD %0t ns: run did not finish in time", $time);
      end_of_test();
    end
  end
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One comparison; case inequality keeps unknowns from matching.
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t ns: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // Address of register k (1 or 2) of port index p.
  function automatic logic [7:0] adr(input int p, input int k);
    return 8'(16 * (p + 1) + k);
  endfunction
  // One bit of every port's register, bit i for port i+1.
  function automatic logic [2:0] col(input bit second, input int b);
    return second ? {c2[2][b], c2[1][b], c2[0][b]} : {c1[2][b], c1[1][b], c1[0][b]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Bus tasks; each is entered just after an edge and leaves just after one. An idle edge
  // follows every strobe, so a second call never raises a strobe in the step that lowered it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1 reg_wr = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1 reg_rd = 1'b0;
    chk(reg_rdata_valid, 1'b1, "read valid");
    chk(reg_rdata, exp, "read data");
    @(posedge clk_sys);
    #1;
  endtask
  // Reads all six registers and checks every settings output against the model.
  task automatic rd_all();
    for (int p = 0; p < 3; p++)
    begin
      rd(adr(p, 1), c1[p]);
      rd(adr(p, 2), c2[p]);
    end
    chk({port_sniffer_dest, port_rx_sniff, port_tx_sniff, port_double_tag}, {col(0, 7), col(0, 6), col(0, 5),
      col(0, 4)}, "mirror settings");
    chk(port_member_mask, {c1[2][2:0], c1[1][2:0], c1[0][2:0]}, "membership");
    chk({port_ingress_filter, port_discard_non_port_default_vid}, {col(1, 6), col(1, 5)}, "filters");
    chk(port_force_fc, {1'b0, c2[1][4], c2[0][4]}, "force flow control");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // One random packet; the expectation follows the forwarding and mirroring rules.
  task automatic pkt();
    logic [31:0] r, r2;
    logic [2:0] base, mask;
    logic [11:0] pv;
    int s;
    logic drop, mon;
    r = $random(seed);
    r2 = $random(seed);
    s = int'(r[1:0]);
    pv = (s < 3) ? port_default_vid[12 * s +: 12] : 12'h000;
    pkt_src_port = r[1:0];
    pkt_dst_lookup = r[4:2];
    pkt_vlan_entry = r2[18:0];
    pkt_vid = r[5] ? pv : r2[31:20];
    pkt_valid = 1'b1;
    @(posedge clk_sys);
    #1 pkt_valid = 1'b0;
    drop = 1'b1;
    mask = 3'h0;
    mon = 1'b0;
    if (s < 3)
    begin
      drop = (c2[s][6] & ~pkt_vlan_entry[16 + s]) | (c2[s][5] & (pkt_vid != pv));
      base = pkt_dst_lookup & c1[s][2:0] & ~(3'h1 << s);
      mon = ~drop & (c1[s][6] | (|(base & col(0, 5))));
      mask = drop ? 3'h0 : base | (mon ? col(0, 7) & ~(3'h1 << s) : 3'h0);
      chk({fwd_push_tag, fwd_tag_vid}, {~drop & c1[s][4], pv}, "tag push");
    end
    chk(fwd_valid, 1'b1, "decision valid");
    chk({fwd_mask, fwd_drop, fwd_monitored}, {mask, drop, mon}, "decision");
    @(posedge clk_sys);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: strap defaults, unmapped accesses, then random traffic.
  initial
  begin
    logic [31:0] r;
    int p;
    nrst = 1'b0;
    {reg_wr, reg_rd, pkt_valid} = 3'h0;
    {reg_addr, reg_wdata, pkt_src_port, pkt_dst_lookup, pkt_vid, pkt_vlan_entry} = '0;
    strap = 8'($random(seed));
    port_default_vid = {4'($random(seed)), 32'($random(seed))};
    c1 = '{{5'h0, strap[0], strap[1], 1'b1}, {5'h0, strap[2], 1'b1, strap[3]}, {5'h0, 1'b1, strap[4], strap[5]}};
    c2 = '{{3'h0, strap[6], 4'h0}, {3'h0, strap[7], 4'h0}, 8'h00};
    repeat (3) @(posedge clk_sys);
    #1 nrst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rd_all();
    wr(8'h13, 8'hFF);
    wr(8'h10, 8'hFF);
    rd(8'h13, 8'h00);
    rd(8'h00, 8'h00);
    c1[1] = 8'h42;
    wr(adr(1, 1), c1[1]);
    rd(adr(1, 1), c1[1]);
    rd_all();
    for (int i = 0; i < 60; i++)
    begin
      r = $random(seed);
      p = (i < 3) ? i : int'(r[31:28]) % 3;
      c1[p] = (i < 3) ? 8'hE7 : r[7:0] & 8'hF7;
      c2[p] = r[15:8] & 8'h7F;
      wr(adr(p, 1), c1[p]);
      wr(adr(p, 2), c2[p]);
      rd_all();
      repeat (6) pkt();
    end
    end_of_test();
  end
endmodule
`default_nettype wire
